//--- el_panel_pkg.sv
// Constants shared by the panel driver control block and its pattern unit.
// Assumes one 200 MHz clock and a plain strobe-driven register port.
//
// Summary of operation
// - Software sets the backup high-drive flag before lighting the panel.
// - Configuration word must be loaded before lighting; last written wins.
// - Flag-set with operand bit 2 lights panel; both pins start driving.
// - Flag-reset with operand bit 2 clears light; both pins stop driving.
// - Panel pin roles exist only when the build option selects them.
// - Bits 8..6 pick pump clock: tap zero, clock, /2, /4, /8.
// - Bits 5..4 pick pump duty: 3/4, 2/3, 1/2 or full time.
// - Bits 3..2 pick discharge rate: tap 8, 7, 6 or 5.
// - Bits 1..0 pick discharge duty: 1/4, 1/3, 1/2 or every slot.
package el_panel_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam int CFG_W  = 9;
  localparam int PRE_W  = 9;

  localparam logic [ADDR_W-1:0] ADDR_FLAG_SET   = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_FLAG_RESET = 4'h4;
  localparam logic [ADDR_W-1:0] ADDR_CONFIG     = 4'h8;
  localparam logic [ADDR_W-1:0] ADDR_STATUS     = 4'hC;

  localparam int BIT_BACKUP = 1;
  localparam int BIT_LIGHT  = 2;
  localparam int BIT_OPTION = 3;

  localparam int PUMP_SEL_HI = 8;
  localparam int PUMP_SEL_LO = 6;
  localparam int PUMP_DUTY_HI = 5;
  localparam int PUMP_DUTY_LO = 4;
  localparam int DIS_RATE_HI = 3;
  localparam int DIS_RATE_LO = 2;
  localparam int DIS_DUTY_HI = 1;
  localparam int DIS_DUTY_LO = 0;

  localparam logic [2:0] PUMP_TAP0 = 3'h0;
  localparam logic [2:0] PUMP_CLK  = 3'h4;
  localparam logic [2:0] PUMP_DIV2 = 3'h5;
  localparam logic [2:0] PUMP_DIV4 = 3'h6;
  localparam logic [2:0] PUMP_DIV8 = 3'h7;

  localparam int TAP_DIV2 = 0;
  localparam int TAP_DIV4 = 1;
  localparam int TAP_DIV8 = 2;
  localparam int TAP_ZERO = 0;
  localparam int TAP_FIVE = 5;
  localparam int TAP_SIX = 6;
  localparam int TAP_SEVEN = 7;
  localparam int TAP_EIGHT = 8;

  localparam logic [1:0] DUTY_SEL0 = 2'h0;
  localparam logic [1:0] DUTY_SEL1 = 2'h1;
  localparam logic [1:0] DUTY_SEL2 = 2'h2;
  localparam logic [1:0] DUTY_SEL3 = 2'h3;

  // Period length and lit slots, in slots of one clock-pulse each.
  localparam logic [2:0] LEN_4 = 3'h4;
  localparam logic [2:0] LEN_3 = 3'h3;
  localparam logic [2:0] LEN_2 = 3'h2;
  localparam logic [2:0] LEN_1 = 3'h1;

  localparam logic [CFG_W-1:0] CONFIG_RESET = 9'h000;
endpackage

//--- el_duty_pattern.sv
// Gated pulse pattern generator for one panel output pin.
// Assumes rate_tick is a one-cycle pulse on the same clock.
`timescale 1ns/1ps
module el_duty_pattern (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       run,
  input  wire logic       rate_tick,
  input  wire logic [2:0] len,
  input  wire logic [2:0] lit,
  output logic            wave
);
  import el_panel_pkg::*;

  logic       phase_reg, phase_next;
  logic [2:0] slot_reg, slot_next;
  logic [2:0] len_reg, len_next;
  logic [2:0] lit_reg, lit_next;
  logic       wave_reg, wave_next;

  always_comb begin
    phase_next = phase_reg;
    slot_next  = slot_reg;
    len_next   = len_reg;
    lit_next   = lit_reg;
    if (!run) begin
      phase_next = 1'b0;
      slot_next  = 3'h0;
      len_next   = len;
      lit_next   = lit;
    end else if (rate_tick) begin
      phase_next = ~phase_reg;
      if (phase_reg) begin
        if (slot_reg + 3'h1 >= len_reg) begin
          slot_next = 3'h0;
          len_next  = len;
          lit_next  = lit;
        end else begin
          slot_next = slot_reg + 3'h1;
        end
      end
    end
    wave_next = run & phase_next & (slot_next < lit_next);
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      phase_reg <= 1'b0;
      slot_reg  <= 3'h0;
      len_reg   <= LEN_4;
      lit_reg   <= LEN_1;
      wave_reg  <= 1'b0;
    end else begin
      phase_reg <= phase_next;
      slot_reg  <= slot_next;
      len_reg   <= len_next;
      lit_reg   <= lit_next;
      wave_reg  <= wave_next;
    end
  end

  assign wave = wave_reg;
endmodule // el_duty_pattern

//--- el_panel_driver_control.sv
// Panel driver control: flag operations, configuration and both pin waves.
// Assumes a strobe register port on clk; shared pin inputs come from logic
// on the same clock.
`timescale 1ns/1ps
module el_panel_driver_control #(
  parameter bit PANEL_PIN_OPTION = 1'b1
) (
  input  wire logic                            clk,
  input  wire logic                            nrst,
  input  wire logic [el_panel_pkg::ADDR_W-1:0] addr,
  input  wire logic [el_panel_pkg::DATA_W-1:0] wdata,
  input  wire logic                            wr,
  input  wire logic                            rd,
  output logic      [el_panel_pkg::DATA_W-1:0] rdata,
  input  wire logic                            shared_pump_in,
  input  wire logic                            shared_discharge_in,
  output logic                                 panel_pump_output,
  output logic                                 panel_discharge_output,
  output logic                                 backup_high_drive_flag,
  output logic                                 light_on
);
  import el_panel_pkg::*;

  logic [CFG_W-1:0]  config_reg, config_next;
  logic              light_reg, light_next;
  logic              backup_reg, backup_next;
  logic [DATA_W-1:0] rdata_reg, rdata_next;
  logic [PRE_W-1:0]  pre_reg, pre_next;
  logic              pump_reg, pump_next;
  logic              dis_reg, dis_next;

  logic              pump_tick, dis_tick;
  logic [2:0]        pump_len, pump_lit, dis_len, dis_lit;
  logic              pump_wave, dis_wave;

  // Flag, configuration and read path. A flag write either only sets or
  // only clears, so a set and a clear of one flag never meet in a cycle.
  always_comb begin
    config_next = config_reg;
    light_next  = light_reg;
    backup_next = backup_reg;
    rdata_next  = '0;
    if (wr) begin
      case (addr)
        ADDR_FLAG_SET: begin
          if (wdata[BIT_LIGHT]) begin
            light_next = 1'b1;
          end
          if (wdata[BIT_BACKUP]) begin
            backup_next = 1'b1;
          end
        end
        ADDR_FLAG_RESET: begin
          if (wdata[BIT_LIGHT]) begin
            light_next = 1'b0;
          end
          // Backup drive clear.
          if (wdata[BIT_BACKUP]) begin
            backup_next = 1'b0;
          end
        end
        ADDR_CONFIG: begin
          config_next = wdata[CFG_W-1:0];
        end
        default: ;
      endcase
    end
    // Read data are registered, so they stand only in the cycle after rd.
    if (rd) begin
      case (addr)
        ADDR_CONFIG: begin
          rdata_next[CFG_W-1:0] = config_reg;
        end
        ADDR_STATUS: begin
          rdata_next[BIT_LIGHT]  = light_reg;
          rdata_next[BIT_BACKUP] = backup_reg;
          rdata_next[BIT_OPTION] = PANEL_PIN_OPTION;
        end
        default: rdata_next = '0;
      endcase
    end
  end

  // Free-running prescaler; each tap ticks once per its own period.
  // Its width covers the slowest discharge tap.
  always_comb begin
    pre_next = pre_reg + 1'b1;
  end

  // A new rate reaches the tick at once; the slot counts of the pattern
  // units wait for the period boundary. Codes 001 to 011 act as tap zero.
  // Pump clock selection.
  always_comb begin
    case (config_reg[PUMP_SEL_HI:PUMP_SEL_LO])
      PUMP_CLK:  pump_tick = 1'b1;
      PUMP_DIV2: pump_tick = &pre_reg[TAP_DIV2:0];
      PUMP_DIV4: pump_tick = &pre_reg[TAP_DIV4:0];
      PUMP_DIV8: pump_tick = &pre_reg[TAP_DIV8:0];
      default:   pump_tick = &pre_reg[TAP_ZERO:0];
    endcase
  end

  always_comb begin
    case (config_reg[DIS_RATE_HI:DIS_RATE_LO])
      DUTY_SEL0: dis_tick = &pre_reg[TAP_EIGHT:0];
      DUTY_SEL1: dis_tick = &pre_reg[TAP_SEVEN:0];
      DUTY_SEL2: dis_tick = &pre_reg[TAP_SIX:0];
      default:   dis_tick = &pre_reg[TAP_FIVE:0];
    endcase
  end

  // Full time is a period of one slot, so every slot carries a pulse.
  // Pump duty pattern.
  always_comb begin
    case (config_reg[PUMP_DUTY_HI:PUMP_DUTY_LO])
      DUTY_SEL0: begin
        pump_len = LEN_4;
        pump_lit = LEN_3;
      end
      DUTY_SEL1: begin
        pump_len = LEN_3;
        pump_lit = LEN_2;
      end
      DUTY_SEL2: begin
        pump_len = LEN_2;
        pump_lit = LEN_1;
      end
      default: begin
        pump_len = LEN_1;
        pump_lit = LEN_1;
      end
    endcase
  end

  // Discharge always lights one slot; only the period length changes.
  // Discharge duty pattern.
  always_comb begin
    case (config_reg[DIS_DUTY_HI:DIS_DUTY_LO])
      DUTY_SEL0: begin
        dis_len = LEN_4;
        dis_lit = LEN_1;
      end
      DUTY_SEL1: begin
        dis_len = LEN_3;
        dis_lit = LEN_1;
      end
      DUTY_SEL2: begin
        dis_len = LEN_2;
        dis_lit = LEN_1;
      end
      default: begin
        dis_len = LEN_1;
        dis_lit = LEN_1;
      end
    endcase
  end

  // Both generators run from the light flag, so they start and stop together.
  el_duty_pattern pump_gen (
    .clk       (clk),
    .nrst      (nrst),
    .run       (light_reg),
    .rate_tick (pump_tick),
    .len       (pump_len),
    .lit       (pump_lit),
    .wave      (pump_wave)
  );

  el_duty_pattern dis_gen (
    .clk       (clk),
    .nrst      (nrst),
    .run       (light_reg),
    .rate_tick (dis_tick),
    .len       (dis_len),
    .lit       (dis_lit),
    .wave      (dis_wave)
  );

  // Without the option the pins carry their other roles, one flop late.
  // Pin role by option.
  always_comb begin
    if (PANEL_PIN_OPTION) begin
      pump_next = pump_wave;
      dis_next  = dis_wave;
    end else begin
      pump_next = shared_pump_in;
      dis_next  = shared_discharge_in;
    end
  end

  // One reset for all state; every output comes straight from a flop.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      config_reg <= CONFIG_RESET;
      light_reg  <= 1'b0;
      backup_reg <= 1'b0;
      rdata_reg  <= '0;
      pre_reg    <= '0;
      pump_reg   <= 1'b0;
      dis_reg    <= 1'b0;
    end else begin
      config_reg <= config_next;
      light_reg  <= light_next;
      backup_reg <= backup_next;
      rdata_reg  <= rdata_next;
      pre_reg    <= pre_next;
      pump_reg   <= pump_next;
      dis_reg    <= dis_next;
    end
  end

  assign rdata                  = rdata_reg;
  assign panel_pump_output      = pump_reg;
  assign panel_discharge_output = dis_reg;
  assign backup_high_drive_flag = backup_reg;
  assign light_on               = light_reg;
endmodule // el_panel_driver_control

//--- el_panel_load.sv
// Panel load model: counts lit cycles and pulse starts on both pins.
// Assumes pins sampled on clk; clr restarts all counts.
`timescale 1ns/1ps
module el_panel_load (
  input  wire logic        clk,
  input  wire logic        pump,
  input  wire logic        dis,
  input  wire logic        clr,
  output logic      [15:0] pump_hi,
  output logic      [15:0] pump_up,
  output logic      [15:0] dis_hi,
  output logic      [15:0] dis_up
);
  logic pump_reg;
  logic dis_reg;
  always_ff @(posedge clk) begin
    pump_reg <= pump;
    dis_reg  <= dis;
    pump_hi  <= clr ? 16'h0 : pump_hi + 16'(pump);
    pump_up  <= clr ? 16'h0 : pump_up + 16'(pump & ~pump_reg);
    dis_hi   <= clr ? 16'h0 : dis_hi + 16'(dis);
    dis_up   <= clr ? 16'h0 : dis_up + 16'(dis & ~dis_reg);
  end
endmodule // el_panel_load

//--- el_panel_checker.sv
// Port checker for the panel driver control block.
// Assumes one clock domain; bound to every driver instance.
`timescale 1ns/1ps
module el_panel_checker #(
  parameter bit PANEL_PIN_OPTION = 1'b1
) (
  input wire logic                            clk,
  input wire logic                            nrst,
  input wire logic [el_panel_pkg::ADDR_W-1:0] addr,
  input wire logic [el_panel_pkg::DATA_W-1:0] wdata,
  input wire logic                            wr,
  input wire logic                            rd,
  input wire logic [el_panel_pkg::DATA_W-1:0] rdata,
  input wire logic                            shared_pump_in,
  input wire logic                            shared_discharge_in,
  input wire logic                            panel_pump_output,
  input wire logic                            panel_discharge_output,
  input wire logic                            backup_high_drive_flag,
  input wire logic                            light_on
);
  import el_panel_pkg::*;
  logic set_wr;
  logic clr_wr;
  assign set_wr = wr && addr == ADDR_FLAG_SET;
  assign clr_wr = wr && addr == ADDR_FLAG_RESET;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  light_set_a: assert property (
    set_wr && wdata[BIT_LIGHT] |=> light_on) else $error("light not set");
  light_clr_a: assert property (
    clr_wr && wdata[BIT_LIGHT] |=> !light_on) else $error("light not off");
  backup_set_a: assert property (
    set_wr && wdata[BIT_BACKUP] |=> backup_high_drive_flag)
    else $error("backup not set");
  backup_clr_a: assert property (
    clr_wr && wdata[BIT_BACKUP] |=> !backup_high_drive_flag)
    else $error("backup not cleared");
  flag_hold_a: assert property (
    !set_wr && !clr_wr |=>
    $stable(light_on) && $stable(backup_high_drive_flag))
    else $error("flag moved without write");
  dark_pins_a: assert property (
    (PANEL_PIN_OPTION && !light_on) [*4] |->
    !panel_pump_output && !panel_discharge_output)
    else $error("pin active while dark");
  rd_idle_a: assert property (
    !$past(rd) |-> rdata == '0) else $error("read data outside slot");
  shared_role_a: assert property (
    !PANEL_PIN_OPTION && nrst |=>
    panel_pump_output == $past(shared_pump_in) &&
    panel_discharge_output == $past(shared_discharge_in))
    else $error("shared pin role not passed");
  status_rd_a: assert property (
    rd && addr == ADDR_STATUS |=> rdata == DATA_W'({PANEL_PIN_OPTION,
    $past(light_on), $past(backup_high_drive_flag), 1'b0}))
    else $error("status read wrong");
  cover property ($rose(light_on));
  cover property ($rose(panel_pump_output));
  cover property ($rose(panel_discharge_output));
endmodule // el_panel_checker
bind el_panel_driver_control el_panel_checker #(
  .PANEL_PIN_OPTION(PANEL_PIN_OPTION)) chk (.*);

//--- testbench.sv
// Self-checking bench for the panel driver control block.
// Assumes the panel load model counts pin activity.
`timescale 1ns/1ps
module testbench;
  import el_panel_pkg::*;
  logic              clk, nrst, wr, rd, sh_p, sh_d, clr;
  logic              pump, dis, backup, light;
  logic              pump0, dis0, sh_p_q, sh_d_q;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata, rdata;
  logic [15:0]       p_hi, p_up, d_hi, d_up;
  int                miscompares, num_checks, cycles;
  int                pdiv[5] = '{2, 1, 2, 4, 8};
  logic [2:0]        psel[5] = '{PUMP_TAP0, PUMP_CLK, PUMP_DIV2,
                                 PUMP_DIV4, PUMP_DIV8};
  el_panel_driver_control dut (.clk(clk), .nrst(nrst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .shared_pump_in(sh_p), .shared_discharge_in(sh_d),
    .panel_pump_output(pump), .panel_discharge_output(dis),
    .backup_high_drive_flag(backup), .light_on(light));
  el_panel_load load (.clk(clk), .pump(pump), .dis(dis), .clr(clr),
    .pump_hi(p_hi), .pump_up(p_up), .dis_hi(d_hi), .dis_up(d_up));
  // Second build without the pin option: pins carry the shared roles.
  el_panel_driver_control #(.PANEL_PIN_OPTION(1'b0)) dut_shared (
    .clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(), .shared_pump_in(sh_p),
    .shared_discharge_in(sh_d), .panel_pump_output(pump0),
    .panel_discharge_output(dis0), .backup_high_drive_flag(),
    .light_on());
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Shared pin roles toggle so the option mux is exercised.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    sh_p <= ~sh_p;
    sh_d <= cycles[3];
    sh_p_q <= sh_p;
    sh_d_q <= sh_d;
    if (cycles == 70000) begin
      miscompares++;
      summarize();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(rdata, exp);
  endtask
  task automatic measure(input int w, ph, pu, dh, du);
    @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    repeat (w) @(posedge clk);
    @(negedge clk);
    chk(p_hi, 16'(ph));
    chk(p_up, 16'(pu));
    chk(d_hi, 16'(dh));
    chk(d_up, 16'(du));
    chk({14'h0, pump0, dis0}, {14'h0, sh_p_q, sh_d_q});
  endtask
  initial begin
    int k, len, lit, dl, dt;
    logic [1:0] dd;
    {nrst, wr, rd, clr, sh_p, sh_d} = 6'h0;
    addr = '0;
    wdata = '0;
    {cycles, miscompares, num_checks} = '0;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    rd_chk(ADDR_STATUS, 16'h0008);
    rd_chk(ADDR_CONFIG, 16'h0000);
    rd_chk(4'h1, 16'h0000);
    wr_reg(ADDR_FLAG_SET, 16'h0002);
    rd_chk(ADDR_STATUS, 16'h000A);
    chk({14'h0, light, backup}, 16'h0001);
    wr_reg(ADDR_CONFIG, 16'h0100);
    wr_reg(ADDR_FLAG_SET, 16'h0004);
    rd_chk(ADDR_STATUS, 16'h000E);
    chk({14'h0, light, backup}, 16'h0003);
    $display("test flags done");
    for (int i = 0; i < 5; i++) begin
      k = i % 4;
      dd = 2'(i + 1);
      len = 4 - k;
      lit = (k == 3) ? 1 : len - 1;
      dl = 4 - int'(dd);
      dt = 512 >> k;
      wr_reg(ADDR_CONFIG, 16'({psel[i], 2'(k), 2'(k), dd}));
      rd_chk(ADDR_CONFIG, 16'({psel[i], 2'(k), 2'(k), dd}));
      repeat (4200) @(posedge clk);
      measure(6144, 6144 * lit / (2 * len),
        6144 * lit / (2 * len * pdiv[i]), 6144 / (2 * dl),
        6144 / (2 * dl * dt));
      $display("test pattern %0d done", i);
    end
    wr_reg(ADDR_FLAG_RESET, 16'h0004);
    repeat (8) @(posedge clk);
    measure(64, 0, 0, 0, 0);
    rd_chk(ADDR_STATUS, 16'h000A);
    chk({14'h0, light, backup}, 16'h0001);
    wr_reg(ADDR_FLAG_RESET, 16'h0002);
    rd_chk(ADDR_STATUS, 16'h0008);
    chk({14'h0, light, backup}, 16'h0000);
    $display("test dark done");
    summarize();
  end
endmodule // testbench
